/* File: rtl/cms_top.sv */
// Message slot control for one CAN channel: APB registers, rx and tx flow
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module cms_top (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic [31:0]      prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	// Protocol controller events
	input  wire logic        pc_bus_idle_i,
	input  wire logic        pc_sof_i,
	input  wire logic [15:0] pc_id_seen_i,
	input  wire logic [15:0] pc_filter_hit_i,
	input  wire logic        pc_rx_ok_i,
	input  wire logic        pc_rx_remote_i,
	input  wire logic        pc_rx_own_i,
	input  wire logic        pc_arb_lost_i,
	input  wire logic        pc_tx_ok_i,
	input  wire logic        pc_err_passive_i,
	input  wire logic        pc_bus_off_i,
	input  wire logic        pc_bus_err_i,
	input  wire logic        pc_wakeup_i,
	// Protocol controller requests
	output logic             tx_start_o,
	output logic [3:0]       tx_slot_o,
	output logic             tx_remote_o,
	output logic             ack_suppress_o,
	output logic             copy_we_o,
	output logic [3:0]       copy_slot_o,
	// Interrupt requests
	output logic             rx_irq_o,
	output logic             tx_irq_o,
	output logic             err_irq_o,
	output logic             wake_irq_o
);
	// Done pulse lands one cycle after the last write cycle
	localparam int A_COPY_MIN = cms_pkg::MSG_COPY_CYCLES - 3;
	localparam int A_COPY_MAX = cms_pkg::MSG_COPY_CYCLES - 3;

	logic [15:0] txreq_q, rxreq_q, remote_q, lock_q;
	logic [15:0] txdone_q, txact_q, fresh_q, upd_q, lost_q, ien_q;
	logic [3:0]  stat_slot_q, cur_tx_q, rx_idx_q;
	logic        rxsucc_q, txsucc_q, rxstate_q, txstate_q;
	logic        loop_q, berr_en_q, pready_q;
	logic [15:0] elig_tx, elig_rx, slot_wr, pend;
	logic [15:0] ev_rx, ev_start, ev_end, ev_conv, ev_resp;
	logic [4:0]  sel_tx, sel_rx;
	logic        start, rx_take, txact_any, acc_wr, setup, mapped;
	logic        copy_done;
	logic [3:0]  cp_slot;
	logic [31:0] rd_d;

	assign pready_o = pready_q;
	assign txact_any = |txact_q;
	assign pend = remote_q & (txreq_q ^ rxreq_q);

	// APB decode
	assign setup  = psel_i & ~penable_i;
	assign acc_wr = psel_i & penable_i & pready_q & pwrite_i;
	// Misaligned slot addresses are refused, not aliased
	assign slot_wr = (acc_wr && paddr_i[7:6] == 2'b00 &&
		paddr_i[1:0] == 2'b00) ? (16'h0001 << paddr_i[5:2]) : 16'h0000;
	assign mapped = (paddr_i[1:0] == 2'b00) && (paddr_i[7:6] == 2'b00 ||
		paddr_i == cms_pkg::OFS_STATUS || paddr_i == cms_pkg::OFS_IRQ_EN ||
		paddr_i == cms_pkg::OFS_CTRL);

	// Eligibility and lowest-slot selection
	always_comb begin
		for (int j = 0; j < 16; j++) begin
			// Config mode slots take part in neither direction
			elig_tx[j] = txreq_q[j] & ~rxreq_q[j] & ~txdone_q[j] &
				(remote_q[j] | ~lock_q[j]);
			elig_rx[j] = pc_filter_hit_i[j] & rxreq_q[j] & ~txreq_q[j] &
				(remote_q[j] == pc_rx_remote_i) &
				(remote_q[j] | ~lock_q[j]);
		end
	end
	assign sel_tx = cms_pkg::first_set(elig_tx);
	assign sel_rx = cms_pkg::first_set(elig_rx);
	assign start = pc_bus_idle_i & ~txact_any & sel_tx[4];
	assign rx_take = pc_rx_ok_i & sel_rx[4] &
		(~pc_rx_own_i | loop_q);

	// Per-slot events
	always_comb begin
		for (int j = 0; j < 16; j++) begin
			ev_rx[j]    = rx_take && sel_rx[3:0] == 4'(j);
			ev_start[j] = start && sel_tx[3:0] == 4'(j);
			ev_end[j]   = txact_q[j] & (pc_arb_lost_i | pc_tx_ok_i);
			ev_conv[j]  = remote_q[j] & txreq_q[j] & ~rxreq_q[j] &
				((pc_tx_ok_i & ~pc_arb_lost_i & txact_q[j]) |
				(pc_id_seen_i[j] & ~txact_q[j]));
			ev_resp[j]  = ev_rx[j] & remote_q[j];
		end
	end

	// Mode bits: software writes, hardware mode changes win
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			txreq_q  <= cms_pkg::SLOT_VEC_RST;
			rxreq_q  <= cms_pkg::SLOT_VEC_RST;
			remote_q <= cms_pkg::SLOT_VEC_RST;
			lock_q   <= cms_pkg::SLOT_VEC_RST;
		end else begin
			for (int j = 0; j < 16; j++) begin
				if (slot_wr[j]) begin
					txreq_q[j]  <= pwdata_i[cms_pkg::B_TXREQ];
					rxreq_q[j]  <= pwdata_i[cms_pkg::B_RXREQ];
					remote_q[j] <= pwdata_i[cms_pkg::B_REMOTE];
					lock_q[j]   <= pwdata_i[cms_pkg::B_LOCK];
				end
				if (ev_conv[j]) begin
					txreq_q[j]  <= 1'b0;
					rxreq_q[j]  <= 1'b1;
					remote_q[j] <= 1'b0;
				end
				if (ev_resp[j]) begin
					txreq_q[j]  <= 1'b1;
					rxreq_q[j]  <= 1'b0;
					remote_q[j] <= 1'b0;
				end
			end
		end
	end

	// Transmit flags
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			txdone_q <= cms_pkg::SLOT_VEC_RST;
			txact_q  <= cms_pkg::SLOT_VEC_RST;
		end else begin
			for (int j = 0; j < 16; j++) begin
				if (slot_wr[j] && !pwdata_i[cms_pkg::B_TXDONE]) begin
					txdone_q[j] <= 1'b0;
				end
				if (txact_q[j] && pc_tx_ok_i && !pc_arb_lost_i) begin
					txdone_q[j] <= 1'b1;
				end
				if (ev_end[j]) begin
					txact_q[j] <= 1'b0;
				end else if (ev_start[j]) begin
					txact_q[j] <= 1'b1;
				end
			end
		end
	end

	// Receive flags; a set in the same cycle beats a software clear
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			fresh_q <= cms_pkg::SLOT_VEC_RST;
			upd_q   <= cms_pkg::SLOT_VEC_RST;
			lost_q  <= cms_pkg::SLOT_VEC_RST;
		end else begin
			for (int j = 0; j < 16; j++) begin
				if (slot_wr[j] && !pwdata_i[cms_pkg::B_FRESH]) begin
					fresh_q[j] <= 1'b0;
				end
				if (slot_wr[j] && !pwdata_i[cms_pkg::B_LOST]) begin
					lost_q[j] <= 1'b0;
				end
				if (copy_done && cp_slot == 4'(j)) begin
					upd_q[j] <= 1'b0;
				end
				if (ev_rx[j]) begin
					fresh_q[j] <= 1'b1;
					upd_q[j]   <= 1'b1;
					if (fresh_q[j]) begin
						lost_q[j] <= 1'b1;
					end
				end
			end
		end
	end

	// Channel status
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			stat_slot_q <= cms_pkg::SLOT_IDX_RST;
			rxsucc_q    <= cms_pkg::BIT_RST;
			txsucc_q    <= cms_pkg::BIT_RST;
			rxstate_q   <= cms_pkg::BIT_RST;
			txstate_q   <= cms_pkg::BIT_RST;
		end else begin
			if (rx_take && ien_q[sel_rx[3:0]]) begin
				stat_slot_q <= sel_rx[3:0];
				rxsucc_q    <= 1'b1;
				txsucc_q    <= 1'b0;
			end else if (pc_tx_ok_i && !pc_arb_lost_i && txact_any &&
				ien_q[cur_tx_q]) begin
				stat_slot_q <= cur_tx_q;
				txsucc_q    <= 1'b1;
				rxsucc_q    <= 1'b0;
			end
			if (pc_sof_i && !txact_any) begin
				rxstate_q <= 1'b1;
			end else if (pc_bus_idle_i) begin
				rxstate_q <= 1'b0;
			end
			if (txact_any && (pc_arb_lost_i || pc_tx_ok_i)) begin
				txstate_q <= 1'b0;
			end else if (start) begin
				txstate_q <= 1'b1;
			end
		end
	end

	// Controller requests and interrupts
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			tx_start_o     <= 1'b0;
			tx_slot_o      <= cms_pkg::SLOT_IDX_RST;
			cur_tx_q       <= cms_pkg::SLOT_IDX_RST;
			rx_idx_q       <= cms_pkg::SLOT_IDX_RST;
			tx_remote_o    <= 1'b0;
			ack_suppress_o <= 1'b0;
			rx_irq_o       <= 1'b0;
			tx_irq_o       <= 1'b0;
			err_irq_o      <= 1'b0;
			wake_irq_o     <= 1'b0;
		end else begin
			tx_start_o <= start;
			rx_idx_q   <= sel_rx[3:0];
			if (start) begin
				tx_slot_o   <= sel_tx[3:0];
				cur_tx_q    <= sel_tx[3:0];
				tx_remote_o <= remote_q[sel_tx[3:0]];
			end
			ack_suppress_o <= loop_q;
			rx_irq_o <= rx_take & ien_q[sel_rx[3:0]];
			tx_irq_o <= pc_tx_ok_i & ~pc_arb_lost_i & txact_any &
				ien_q[cur_tx_q];
			err_irq_o <= pc_err_passive_i | pc_bus_off_i |
				(pc_bus_err_i & berr_en_q);
			wake_irq_o <= pc_wakeup_i;
		end
	end

	// Message copy into slot storage
	cms_copy_seq u_copy (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.start_i   (rx_take),
		.slot_i    (sel_rx[3:0]),
		.we_o      (copy_we_o),
		.slot_o    (cp_slot),
		.done_o    (copy_done)
	);
	assign copy_slot_o = cp_slot;

	// Channel configuration registers
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ien_q     <= cms_pkg::SLOT_VEC_RST;
			loop_q    <= cms_pkg::BIT_RST;
			berr_en_q <= cms_pkg::BIT_RST;
		end else if (acc_wr) begin
			if (paddr_i == cms_pkg::OFS_IRQ_EN) begin
				ien_q <= pwdata_i[15:0];
			end
			if (paddr_i == cms_pkg::OFS_CTRL) begin
				loop_q    <= pwdata_i[cms_pkg::B_LOOP];
				berr_en_q <= pwdata_i[cms_pkg::B_BERR_EN];
			end
		end
	end

	// Read data mux
	always_comb begin
		rd_d = 32'h0000_0000;
		if (paddr_i[7:6] == 2'b00) begin
			rd_d[cms_pkg::B_TXDONE] = txdone_q[paddr_i[5:2]];
			rd_d[cms_pkg::B_TXACT]  = txact_q[paddr_i[5:2]];
			rd_d[cms_pkg::B_FRESH]  = fresh_q[paddr_i[5:2]];
			rd_d[cms_pkg::B_UPD]    = upd_q[paddr_i[5:2]];
			rd_d[cms_pkg::B_LOST]   = lost_q[paddr_i[5:2]];
			rd_d[cms_pkg::B_PEND]   = pend[paddr_i[5:2]];
			rd_d[cms_pkg::B_REMOTE] = remote_q[paddr_i[5:2]];
			rd_d[cms_pkg::B_LOCK]   = lock_q[paddr_i[5:2]];
			rd_d[cms_pkg::B_RXREQ]  = rxreq_q[paddr_i[5:2]];
			rd_d[cms_pkg::B_TXREQ]  = txreq_q[paddr_i[5:2]];
		end else if (paddr_i == cms_pkg::OFS_STATUS) begin
			rd_d[cms_pkg::B_SLOT_LO +: 4] = stat_slot_q;
			rd_d[cms_pkg::B_RXSUCC]  = rxsucc_q;
			rd_d[cms_pkg::B_TXSUCC]  = txsucc_q;
			rd_d[cms_pkg::B_RXSTATE] = rxstate_q;
			rd_d[cms_pkg::B_TXSTATE] = txstate_q;
		end else if (paddr_i == cms_pkg::OFS_IRQ_EN) begin
			rd_d[15:0] = ien_q;
		end else if (paddr_i == cms_pkg::OFS_CTRL) begin
			rd_d[cms_pkg::B_LOOP]    = loop_q;
			rd_d[cms_pkg::B_BERR_EN] = berr_en_q;
		end
	end

	// APB answer in the first cycle of the access phase
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pready_q  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0000_0000;
		end else begin
			pready_q <= setup;
			if (setup) begin
				pslverr_o <= ~mapped;
				prdata_o  <= (mapped && !pwrite_i) ? rd_d : 32'h0000_0000;
			end
		end
	end

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_tx_start_sets: assert property (
		start |=> txact_q[tx_slot_o] && txstate_q && tx_start_o)
		else $error("tx start did not mark slot transmitting");
	a_arb_clears: assert property (
		pc_arb_lost_i && txact_any |=> !txact_any && !txstate_q)
		else $error("arbitration loss left tx active");
	a_tx_done_flag: assert property (
		pc_tx_ok_i && !pc_arb_lost_i && txact_any
		|=> txdone_q[cur_tx_q] && !txact_q[cur_tx_q])
		else $error("tx completion did not set sent flag");
	a_rx_flags: assert property (
		rx_take |=> fresh_q[rx_idx_q] && upd_q[rx_idx_q])
		else $error("reception did not set fresh and updating");
	a_copy_release: assert property (
		rx_take ##1 (!rx_take)[*4] |-> ##[A_COPY_MIN:A_COPY_MAX] copy_done)
		else $error("message copy did not finish in time");
	a_rx_status: assert property (
		rx_take && ien_q[sel_rx[3:0]]
		|=> rx_irq_o && rxsucc_q && stat_slot_q == rx_idx_q)
		else $error("rx interrupt or status wrong");
	a_overwrite: assert property (
		rx_take && fresh_q[sel_rx[3:0]] |=> lost_q[rx_idx_q])
		else $error("overwrite not flagged");
	a_own_drop: assert property (
		pc_rx_ok_i && pc_rx_own_i && !loop_q |-> !rx_take)
		else $error("own frame stored in normal mode");
	a_lowest_slot: assert property (
		rx_take |-> (elig_rx & ((16'h0001 << sel_rx[3:0]) - 16'h0001))
		== 16'h0000)
		else $error("rx slot not the lowest match");
	a_lock_hold: assert property (
		start |-> remote_q[sel_tx[3:0]] || !lock_q[sel_tx[3:0]])
		else $error("locked response transmitted");
	a_rtr_answer: assert property (
		rx_take && remote_q[sel_rx[3:0]]
		|=> txreq_q[rx_idx_q] && !rxreq_q[rx_idx_q] && !pend[rx_idx_q])
		else $error("remote reception did not arm response");
	a_rx_state: assert property (
		pc_sof_i && !txact_any |=> rxstate_q)
		else $error("receiver state not set on start of frame");

	c_tx_start:  cover property (start);
	c_overwrite: cover property (rx_take && fresh_q[sel_rx[3:0]]);
	c_rtr_resp:  cover property (rx_take && remote_q[sel_rx[3:0]]);
	c_arb_lost:  cover property (pc_arb_lost_i && txact_any);
endmodule

/* File: include/cms_pkg.sv */
// Package: register map, field layout and helpers for the message slots
package cms_pkg;
	localparam int NSLOT = 16;
	localparam int SLOT_W = 4;
	localparam int ADDR_W = 8;

	// Byte offsets
	localparam logic [7:0] OFS_SLOT_BASE = 8'h00;
	localparam logic [7:0] OFS_STATUS    = 8'h40;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h44;
	localparam logic [7:0] OFS_CTRL      = 8'h48;

	// Slot control word fields
	localparam int B_TXDONE = 0;
	localparam int B_TXACT  = 1;
	localparam int B_FRESH  = 2;
	localparam int B_UPD    = 3;
	localparam int B_LOST   = 4;
	localparam int B_PEND   = 5;
	localparam int B_REMOTE = 6;
	localparam int B_LOCK   = 7;
	localparam int B_RXREQ  = 8;
	localparam int B_TXREQ  = 9;

	// Status word fields
	localparam int B_SLOT_LO = 0;
	localparam int B_RXSUCC  = 4;
	localparam int B_TXSUCC  = 5;
	localparam int B_RXSTATE = 6;
	localparam int B_TXSTATE = 7;

	// Channel control fields
	localparam int B_LOOP    = 0;
	localparam int B_BERR_EN = 1;

	// Reset values
	localparam logic [15:0] SLOT_VEC_RST = 16'h0000;
	localparam logic [3:0]  SLOT_IDX_RST = 4'h0;
	localparam logic        BIT_RST      = 1'b0;

	// Cycles to copy a received message into slot storage
	localparam int MSG_COPY_CYCLES = 4;

	// Lowest set bit: {found, index}
	function automatic logic [4:0] first_set(input logic [15:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 15; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction
endpackage

/* File: rtl/cms_copy_seq.sv */
// Sequencer that writes a received message into slot storage
`timescale 1ns/1ps
module cms_copy_seq #(
	parameter int COPY_CYCLES = cms_pkg::MSG_COPY_CYCLES
) (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// Request
	input  wire logic       start_i,
	input  wire logic [3:0] slot_i,
	// Storage write and completion
	output logic            we_o,
	output logic [3:0]      slot_o,
	output logic            done_o
);
	typedef enum logic {CMS_IDLE, CMS_COPY} cms_copy_st_t;

	cms_copy_st_t st_q;
	logic [7:0]   cnt_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			st_q   <= CMS_IDLE;
			cnt_q  <= 8'h00;
			we_o   <= 1'b0;
			slot_o <= cms_pkg::SLOT_IDX_RST;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i) begin
				// A new message restarts the copy
				st_q   <= CMS_COPY;
				cnt_q  <= 8'(COPY_CYCLES - 1);
				we_o   <= 1'b1;
				slot_o <= slot_i;
			end else begin
				unique case (st_q)
					CMS_IDLE: begin
						we_o <= 1'b0;
					end
					CMS_COPY: begin
						if (cnt_q == 8'h00) begin
							st_q   <= CMS_IDLE;
							we_o   <= 1'b0;
							done_o <= 1'b1;
						end else begin
							cnt_q <= cnt_q - 8'h01;
						end
					end
				endcase
			end
		end
	end
endmodule

/* File: tb/cms_pc_model.sv */
// Protocol controller stand-in: frame timing and transmit outcomes
`timescale 1ns/1ps
module cms_pc_model #(
	parameter int FRAME = 12
) (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// Controls from the bench
	input  wire logic tx_start_i,
	input  wire logic busy_i,
	input  wire logic lose_i,
	// Bus events
	output logic      bus_idle_o,
	output logic      tx_ok_o,
	output logic      arb_lost_o
);
	logic       act_q;
	logic [7:0] cnt_q;
	logic       end_w;

	// Idle only between frames and after the interframe gap
	assign bus_idle_o = !act_q && cnt_q == 8'h00 && !busy_i;
	assign end_w      = act_q && cnt_q == 8'h01;

	// Frame in flight, then a gap of the same length
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			act_q <= 1'b0;
			cnt_q <= 8'h00;
		end else if (tx_start_i) begin
			act_q <= 1'b1;
			cnt_q <= 8'(FRAME);
		end else if (end_w) begin
			act_q <= 1'b0;
			cnt_q <= 8'(FRAME);
		end else if (cnt_q != 8'h00) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// Outcome only for a frame that was started
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_ok_o    <= 1'b0;
			arb_lost_o <= 1'b0;
		end else begin
			tx_ok_o    <= end_w && !lose_i;
			arb_lost_o <= end_w && lose_i;
		end
	end
endmodule

/* File: tb/cms_top_tb_top.sv */
// Testbench: APB sequences against the slot controller
`timescale 1ns/1ps
module cms_top_tb_top;
	localparam logic [31:0] ONE  = 32'h0000_0001;
	localparam logic [31:0] DON  = ONE << cms_pkg::B_TXDONE;
	localparam logic [31:0] ACT  = ONE << cms_pkg::B_TXACT;
	localparam logic [31:0] FRS  = ONE << cms_pkg::B_FRESH;
	localparam logic [31:0] UPD  = ONE << cms_pkg::B_UPD;
	localparam logic [31:0] LST  = ONE << cms_pkg::B_LOST;
	localparam logic [31:0] PND  = ONE << cms_pkg::B_PEND;
	localparam logic [31:0] REM  = ONE << cms_pkg::B_REMOTE;
	localparam logic [31:0] LCK  = ONE << cms_pkg::B_LOCK;
	localparam logic [31:0] RXQ  = ONE << cms_pkg::B_RXREQ;
	localparam logic [31:0] TXQ  = ONE << cms_pkg::B_TXREQ;
	localparam logic [31:0] RXSS = ONE << cms_pkg::B_RXSUCC;
	localparam logic [31:0] TXSS = ONE << cms_pkg::B_TXSUCC;
	localparam logic [31:0] RXST = ONE << cms_pkg::B_RXSTATE;
	localparam logic [31:0] TXST = ONE << cms_pkg::B_TXSTATE;
	localparam logic [7:0]  ST   = cms_pkg::OFS_STATUS;
	localparam logic [7:0]  CT   = cms_pkg::OFS_CTRL;

	logic        clk, rst, psel, pen, pwr, sof, rxok, rrem, rown, busy;
	logic        lose, perr, pslverr, pready, txs, txrem, acks, cwe;
	logic        ri, ti, ei, wi, idle, txok, arbl, pas, boff, berr, wake;
	logic        lrem;
	logic [7:0]  padr;
	logic [31:0] pwd, prd, rd;
	logic [15:0] ids, hit;
	logic [3:0]  tslot, cs, lslot, cslot;
	int          err_count = 0, num_checks = 0, s;
	int          ns = 0, nok = 0, nl = 0, nri = 0, nti = 0;
	int          ne = 0, nw = 0, nc = 0;

	cms_top cms_top_i (
		.ref_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd), .prdata_o(prd),
		.pready_o(pready), .pslverr_o(pslverr), .pc_bus_idle_i(idle),
		.pc_sof_i(sof), .pc_id_seen_i(ids), .pc_filter_hit_i(hit),
		.pc_rx_ok_i(rxok), .pc_rx_remote_i(rrem), .pc_rx_own_i(rown),
		.pc_arb_lost_i(arbl), .pc_tx_ok_i(txok), .pc_err_passive_i(pas),
		.pc_bus_off_i(boff), .pc_bus_err_i(berr), .pc_wakeup_i(wake),
		.tx_start_o(txs), .tx_slot_o(tslot), .tx_remote_o(txrem),
		.ack_suppress_o(acks), .copy_we_o(cwe), .copy_slot_o(cs),
		.rx_irq_o(ri), .tx_irq_o(ti), .err_irq_o(ei), .wake_irq_o(wi));

	cms_pc_model cms_pc_model_i (
		.clk_i(clk), .rst_i(rst), .tx_start_i(txs), .busy_i(busy),
		.lose_i(lose), .bus_idle_o(idle), .tx_ok_o(txok),
		.arb_lost_o(arbl));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Event counters on the design and controller model outputs
	always @(posedge clk) begin
		ns  <= ns + int'(txs === 1'b1);
		nok <= nok + int'(txok === 1'b1);
		nl  <= nl + int'(arbl === 1'b1);
		nri <= nri + int'(ri === 1'b1);
		nti <= nti + int'(ti === 1'b1);
		ne  <= ne + int'(ei === 1'b1);
		nw  <= nw + int'(wi === 1'b1);
		nc  <= nc + int'(cwe === 1'b1);
		if (txs === 1'b1) begin
			lslot <= tslot;
			lrem  <= txrem;
		end
		if (cwe === 1'b1) begin
			cslot <= cs;
		end
	end

	function automatic logic [7:0] sa(input int j);
		return cms_pkg::OFS_SLOT_BASE + 8'(4 * j);
	endfunction

	task automatic chk(input string n, input logic [31:0] v, e);
		num_checks++;
		if (v !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", n, e, v);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen  <= 1'b0;
		pwr  <= w;
		padr <= a;
		pwd  <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd   = prd;
		perr = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
	endtask

	task automatic rdc(input string n, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, rd, e);
	endtask

	task automatic wev(ref int c);
		int t;
		t = c;
		for (int i = 0; i < 80 && c == t; i++) @(posedge clk);
		if (c == t) begin
			err_count++;
			$display("unexpected event wait: expected change seen none");
		end
	endtask

	// Pulse codes: 0 sof, 1 passive, 2 bus off, 3 bus error, 4 wake
	task automatic drv(input int k, input logic v);
		case (k)
			0: sof <= v;
			1: pas <= v;
			2: boff <= v;
			3: berr <= v;
			default: wake <= v;
		endcase
	endtask

	task automatic pls(input int k);
		@(posedge clk);
		drv(k, 1'b1);
		@(posedge clk);
		drv(k, 1'b0);
	endtask

	// Start of frame, then a good frame; qualifiers turn over afterwards
	task automatic rx(input logic [15:0] h, input logic r, o);
		pls(0);
		rxok <= 1'b1;
		hit  <= h;
		rrem <= r;
		rown <= o;
		@(posedge clk);
		rxok <= 1'b0;
		hit  <= ~h;
		rrem <= ~r;
		rown <= ~o;
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#50000;
		err_count++;
		results;
	end

	initial begin
		rst = 1'b1;
		{psel, pen, pwr, sof, rxok, rrem, rown, busy, lose} = '0;
		{pas, boff, berr, wake} = '0;
		{padr, pwd, ids, hit} = '0;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rdc("slot reset", sa(0), 32'h0000_0000);
		rdc("status reset", ST, 32'h0000_0000);
		apb(1'b1, cms_pkg::OFS_IRQ_EN, 32'h0000_FFFF);
		apb(1'b1, sa(2), 32'h0000_0000);
		apb(1'b1, sa(2), TXQ);
		wev(ns);
		chk("tx slot", {28'h0, lslot}, 32'h0000_0002);
		chk("tx remote", {31'h0, lrem}, 32'h0000_0000);
		rdc("tx active", sa(2), TXQ | ACT);
		rdc("tx state", ST, TXST);
		wev(nok);
		rdc("tx done", sa(2), TXQ | DON);
		rdc("tx status", ST, 32'h2 | TXSS);
		chk("tx irq", 32'(nti), 32'h0000_0001);
		apb(1'b1, sa(2), 32'h0000_0000);
		rdc("tx cleared", sa(2), 32'h0000_0000);
		lose <= 1'b1;
		apb(1'b1, sa(2), TXQ);
		wev(nl);
		lose <= 1'b0;
		rdc("lost slot", sa(2), TXQ);
		rdc("lost state", ST, 32'h2 | TXSS);
		wev(nok);
		chk("retry", 32'(ns), 32'h0000_0003);
		apb(1'b1, sa(4), 32'h0000_0000);
		apb(1'b1, sa(4), TXQ | REM);
		wev(ns);
		chk("remote frame", {31'h0, lrem}, 32'h0000_0001);
		rdc("remote pend", sa(4), TXQ | REM | ACT | PND);
		wev(nok);
		rdc("remote done", sa(4), RXQ | DON);
		busy <= 1'b1;
		apb(1'b1, sa(5), 32'h0000_0000);
		apb(1'b1, sa(5), TXQ | REM);
		@(posedge clk);
		ids <= 16'h0020;
		@(posedge clk);
		ids <= 16'h0000;
		rdc("id seen", sa(5), RXQ);
		apb(1'b1, sa(6), RXQ);
		apb(1'b1, sa(7), RXQ);
		s = nc;
		rx(16'h00C0, 1'b0, 1'b0);
		repeat (8) @(posedge clk);
		chk("copy len", 32'(nc - s), cms_pkg::MSG_COPY_CYCLES);
		chk("copy slot", {28'h0, cslot}, 32'h0000_0006);
		rdc("rx data", sa(6), RXQ | FRS);
		rdc("rx other", sa(7), RXQ);
		rdc("rx status", ST, 32'h6 | RXSS | RXST);
		rx(16'h00C0, 1'b0, 1'b0);
		rdc("updating", sa(6), RXQ | FRS | LST | UPD);
		repeat (8) @(posedge clk);
		rdc("overwrite", sa(6), RXQ | FRS | LST);
		chk("rx irq", 32'(nri), 32'h0000_0002);
		apb(1'b1, sa(6), RXQ);
		rdc("fresh clear", sa(6), RXQ);
		rx(16'h0080, 1'b0, 1'b1);
		repeat (8) @(posedge clk);
		rdc("own drop", sa(7), RXQ);
		apb(1'b1, CT, 32'h0000_0001);
		rx(16'h0080, 1'b0, 1'b1);
		repeat (8) @(posedge clk);
		rdc("loop rx", sa(7), RXQ | FRS);
		chk("no ack", {31'h0, acks}, 32'h0000_0001);
		apb(1'b1, sa(8), 32'h0000_0000);
		apb(1'b1, sa(8), RXQ | REM | LCK);
		rdc("rtr pend", sa(8), RXQ | REM | LCK | PND);
		rx(16'h0100, 1'b1, 1'b0);
		repeat (8) @(posedge clk);
		busy <= 1'b0;
		s = ns;
		repeat (30) @(posedge clk);
		apb(1'b0, sa(8), 32'h0000_0000);
		chk("rtr to tx", rd & (TXQ | RXQ | REM | LCK | PND), TXQ | LCK);
		chk("lock holds", 32'(ns - s), 32'h0000_0000);
		apb(1'b1, sa(8), TXQ);
		wev(ns);
		chk("answer", {28'h0, lslot}, 32'h0000_0008);
		wev(nok);
		s = ne;
		pls(1);
		pls(2);
		pls(3);
		apb(1'b1, CT, 32'h0000_0003);
		pls(3);
		pls(4);
		repeat (2) @(posedge clk);
		chk("err irq", 32'(ne - s), 32'h0000_0003);
		chk("wake irq", 32'(nw), 32'h0000_0001);
		apb(1'b0, 8'h80, 32'h0000_0000);
		chk("unmapped err", {31'h0, perr}, 32'h0000_0001);
		chk("unmapped data", rd, 32'h0000_0000);
		apb(1'b1, 8'h25, TXQ);
		chk("misaligned err", {31'h0, perr}, 32'h0000_0001);
		rdc("misaligned ignored", sa(9), 32'h0000_0000);
		apb(1'b1, ST, 32'h0000_00FF);
		rdc("status ro", ST, 32'h8 | TXSS);
		results;
	end
endmodule
